// >>> rtl/charger_led_config_regs.sv
// configuration bank for charger temperature trim, comparator, indicator and isolation switch
// How it works
// RL1: bits 3:2 pick termination voltage subtraction 60, 100, 160, 200 mV.
// RL2: bits 5:4 pick adjusted charge current 25, 50, 75, 100 percent.
// RL3: debounce codes 1..3 give 100 us, 1 ms, 10 ms; code 0 reserved.
// RL4: bit 2 sets comparator threshold, 50 mV clear, 175 mV set.
// RL5: duty bits 5:0 give on-time N/32 of period; zero keeps indicator off.
// RL6: duty bit 6 enables brightness ramping.
// RL7: duty bit 7 enables the indicator driver.
// RL8: bit 0 clear opens isolation switch on battery overvoltage.
// RL9: bit 1 clear opens isolation switch on watchdog fault.
// RL10: bit 2 clear opens isolation switch while battery too cold or hot.
// RL11: bit 3 clear opens isolation switch during thermal shutdown.
// RL12: bit 4 clear opens switch on timer fault; only power-on reset clears it.
// RL13: frequency bits 1:0 give 1.0, 0.5, 256 and 8.0 Hz.
// RL14: current bits 3:2 accept only code 1 (6.0 mA); others are reserved.
// RL15: pattern bit picks lit/flash for charging versus fault; off when done.
// RL16: override bit hands indicator to software, else charger state drives it.
// RL17: core-digital reset zeroes every field except the timer-fault bit.
// RL18: with driver enable clear the indicator output stays off.
module charger_led_config_regs #(
    parameter int SLOT0_CYC     = charger_led_pkg::SLOT0_CYC,     // slot length at 1.0 Hz
    parameter int SLOT1_CYC     = charger_led_pkg::SLOT1_CYC,     // slot length at 0.5 Hz
    parameter int SLOT2_CYC     = charger_led_pkg::SLOT2_CYC,     // slot length at 256 Hz
    parameter int SLOT3_CYC     = charger_led_pkg::SLOT3_CYC,     // slot length at 8.0 Hz
    parameter int DEB_SHORT_CYC = charger_led_pkg::DEB_SHORT_CYC, // 100 us debounce
    parameter int DEB_MID_CYC   = charger_led_pkg::DEB_MID_CYC,   // 1 ms debounce
    parameter int DEB_LONG_CYC  = charger_led_pkg::DEB_LONG_CYC   // 10 ms debounce
) (
    input  wire logic                     mclk,                  // 200 MHz clock
    input  wire logic                     resetn,                // power-on reset, low
    input  wire logic                     core_digital_reset_n,  // core reset, low
    input  wire logic [7:0]               reg_addr,              // register offset
    input  wire logic [7:0]               reg_wdata,             // write data
    input  wire logic                     reg_wr,                // write strobe
    input  wire logic                     reg_rd,                // read strobe
    output logic      [7:0]               reg_rdata,             // read data
    output logic                          reg_rvalid,            // read data valid pulse
    input  wire charger_led_pkg::faults_t fault_in,              // fault conditions
    input  wire logic                     charging,              // charger is charging
    input  wire logic                     charger_fault,         // charger fault state
    input  wire logic                     charge_done,           // charge done state
    input  wire logic                     input_sys_cmp_raw,     // raw comparator level
    output logic                          input_sys_ok,          // debounced comparator
    output logic                          input_sys_threshold,   // 0: 50 mV, 1: 175 mV
    output logic      [1:0]               term_voltage_subtract, // subtraction code
    output logic      [1:0]               temp_charge_current_pct, // current code
    output logic      [1:0]               indicator_current,     // current code
    output logic                          indicator_out,         // indicator drive
    output logic                          battery_isolation_switch_open // switch open
);
    charger_led_pkg::state_t st;
    charger_led_pkg::state_t next_st;

    // slot length for the chosen indicator frequency
    function automatic logic [23:0] slot_len(input logic [1:0] freq);
        unique case (freq)
            2'h0: slot_len = 24'(SLOT0_CYC);
            2'h1: slot_len = 24'(SLOT1_CYC);
            2'h2: slot_len = 24'(SLOT2_CYC);
            2'h3: slot_len = 24'(SLOT3_CYC);
        endcase
    endfunction

    // debounce length; reserved code 0 falls back to the shortest time
    function automatic logic [23:0] deb_len(input logic [1:0] code);
        unique case (code)
            2'h0: deb_len = 24'(DEB_SHORT_CYC);
            2'h1: deb_len = 24'(DEB_SHORT_CYC);
            2'h2: deb_len = 24'(DEB_MID_CYC);
            2'h3: deb_len = 24'(DEB_LONG_CYC);
        endcase
    endfunction

    // register read mux, unmapped offsets read zero
    function automatic logic [7:0] read_reg(input charger_led_pkg::cfg_t c,
                                            input logic [7:0] a);
        unique case (a)
            charger_led_pkg::TEMP_ADJUST_ADDR:    read_reg = c.temp_adjust;
            charger_led_pkg::INPUT_SYS_ADDR:      read_reg = c.input_sys;
            charger_led_pkg::INDICATOR_DUTY_ADDR: read_reg = c.duty;
            charger_led_pkg::FAULT_SWITCH_ADDR:   read_reg = c.fault_switch;
            charger_led_pkg::INDICATOR_CFG_ADDR:  read_reg = c.indicator;
            charger_led_pkg::CHARGER_KEY_ADDR:    read_reg = c.key;
            default:                              read_reg = 8'h00;
        endcase
    endfunction

    // next-state logic for registers, indicator pwm, debounce and switch
    always_comb begin
        logic [5:0]  duty;
        logic [5:0]  shown;
        logic [1:0]  freq;
        logic [1:0]  cur;
        logic        tick;
        logic        period_end;
        logic        pwm_on;
        logic        pattern;
        logic        want;
        logic        en;
        duty       = 6'h00;
        shown      = 6'h00;
        freq       = 2'h0;
        cur        = 2'h0;
        tick       = 1'b0;
        period_end = 1'b0;
        pwm_on     = 1'b0;
        pattern    = 1'b0;
        want       = 1'b0;
        en         = 1'b0;
        next_st    = st;
        next_st.rvalid = 1'b0;

        // register writes; low bits of the temperature register are not held here
        if (reg_wr) begin
            unique case (reg_addr)
                charger_led_pkg::TEMP_ADJUST_ADDR:
                    next_st.cfg.temp_adjust = reg_wdata & charger_led_pkg::TEMP_ADJUST_MASK;
                charger_led_pkg::INPUT_SYS_ADDR:      next_st.cfg.input_sys = reg_wdata;
                charger_led_pkg::INDICATOR_DUTY_ADDR: next_st.cfg.duty = reg_wdata;
                charger_led_pkg::FAULT_SWITCH_ADDR:   next_st.cfg.fault_switch = reg_wdata;
                charger_led_pkg::INDICATOR_CFG_ADDR: begin
                    cur = reg_wdata[charger_led_pkg::CURRENT_LSB +: 2];
                    next_st.cfg.indicator = reg_wdata;
                    // reserved current codes are dropped, the field keeps its value
                    if (cur != charger_led_pkg::CURRENT_6MA) begin
                        next_st.cfg.indicator[charger_led_pkg::CURRENT_LSB +: 2] =
                            st.cfg.indicator[charger_led_pkg::CURRENT_LSB +: 2]; // RL14
                    end
                end
                charger_led_pkg::CHARGER_KEY_ADDR:    next_st.cfg.key = reg_wdata;
                default: ;
            endcase
        end

        // reads answer one cycle after the strobe
        if (reg_rd) begin
            next_st.rdata  = read_reg(st.cfg, reg_addr);
            next_st.rvalid = 1'b1;
        end

        // comparator debounce: the new level must hold for the whole time
        if (input_sys_cmp_raw == st.input_sys_ok) begin
            next_st.deb_cnt = 24'h000000;
        end else if (st.deb_cnt >=
                     deb_len(st.cfg.input_sys[charger_led_pkg::DEBOUNCE_LSB +: 2]) - 24'h000001)
        begin
            next_st.input_sys_ok = input_sys_cmp_raw; // RL3
            next_st.deb_cnt      = 24'h000000;
        end else begin
            next_st.deb_cnt = st.deb_cnt + 24'h000001;
        end

        // indicator slot timer, 32 slots per pwm period
        en   = st.cfg.duty[charger_led_pkg::DRIVER_EN_BIT];
        duty = st.cfg.duty[charger_led_pkg::DUTY_LSB +: 6];
        freq = st.cfg.indicator[charger_led_pkg::FREQ_LSB +: 2];
        if (!en) begin
            // timers held so a fresh enable starts at slot zero
            next_st.slot_cnt    = 24'h000000; // RL7
            next_st.slot        = 5'h00;
            next_st.flash_phase = 1'b0;
        end else if (st.slot_cnt >= slot_len(freq) - 24'h000001) begin
            tick             = 1'b1; // RL13
            next_st.slot_cnt = 24'h000000;
            next_st.slot     = st.slot + 5'h01;
        end else begin
            next_st.slot_cnt = st.slot_cnt + 24'h000001;
        end
        period_end = tick && (st.slot == 5'h1f);
        if (period_end) begin
            next_st.flash_phase = ~st.flash_phase;
        end

        // ramp moves one step per period toward the set duty
        if (!st.cfg.duty[charger_led_pkg::RAMP_BIT]) begin
            next_st.ramp_duty = duty; // RL6
        end else if (period_end && st.ramp_duty < duty) begin
            next_st.ramp_duty = st.ramp_duty + 6'h01; // RL6
        end else if (period_end && st.ramp_duty > duty) begin
            next_st.ramp_duty = st.ramp_duty - 6'h01; // RL6
        end
        shown = st.ramp_duty;

        // lit for slot indexes below the duty; codes past 31 stay lit
        pwm_on = (shown >= charger_led_pkg::DUTY_SLOTS) || ({1'b0, st.slot} < shown); // RL5

        // charger state picks lit, flashing or off; fault outranks charging
        pattern = st.cfg.indicator[charger_led_pkg::PATTERN_BIT];
        if (st.cfg.indicator[charger_led_pkg::OVERRIDE_BIT]) begin
            want = pwm_on; // RL16
        end else if (charger_fault) begin
            want = pattern ? pwm_on : (pwm_on && st.flash_phase); // RL15
        end else if (charging && !charge_done) begin
            want = pattern ? (pwm_on && st.flash_phase) : pwm_on; // RL15
        end else begin
            want = 1'b0; // RL15
        end
        next_st.indicator_out = en && want; // RL18

        // each fault opens the switch unless its keep bit is set
        next_st.switch_open =
            (fault_in.overvoltage &&
             !st.cfg.fault_switch[charger_led_pkg::OVP_KEEP_BIT]) || // RL8
            (fault_in.watchdog &&
             !st.cfg.fault_switch[charger_led_pkg::WDOG_KEEP_BIT]) || // RL9
            (fault_in.thermistor &&
             !st.cfg.fault_switch[charger_led_pkg::THERM_KEEP_BIT]) || // RL10
            (fault_in.thermal_shutdown &&
             !st.cfg.fault_switch[charger_led_pkg::TSHDN_KEEP_BIT]) || // RL11
            (fault_in.timer &&
             !st.cfg.fault_switch[charger_led_pkg::TIMER_KEEP_BIT]); // RL12

        // core reset wins over a write in the same cycle but spares the timer bit
        if (!core_digital_reset_n) begin
            next_st.cfg.temp_adjust  = charger_led_pkg::CFG_RESET; // RL17
            next_st.cfg.input_sys    = charger_led_pkg::CFG_RESET; // RL17
            next_st.cfg.duty         = charger_led_pkg::CFG_RESET; // RL17
            next_st.cfg.indicator    = charger_led_pkg::CFG_RESET; // RL17
            next_st.cfg.key          = charger_led_pkg::CFG_RESET; // RL17
            next_st.cfg.fault_switch = charger_led_pkg::CFG_RESET; // RL17
            next_st.cfg.fault_switch[charger_led_pkg::TIMER_KEEP_BIT] =
                st.cfg.fault_switch[charger_led_pkg::TIMER_KEEP_BIT]; // RL12
        end
    end

    // power-on reset clears everything including the timer-fault bit
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            st <= '0; // RL12
        end else begin
            st <= next_st;
        end
    end

    // outputs come straight from state flops
    assign reg_rdata                     = st.rdata;
    assign reg_rvalid                    = st.rvalid;
    assign input_sys_ok                  = st.input_sys_ok;
    assign input_sys_threshold           = st.cfg.input_sys[charger_led_pkg::THRESHOLD_BIT]; // RL4
    assign term_voltage_subtract         = st.cfg.temp_adjust[charger_led_pkg::TERM_V_LSB +: 2]; // RL1
    assign temp_charge_current_pct       = st.cfg.temp_adjust[charger_led_pkg::CHG_PCT_LSB +: 2]; // RL2
    assign indicator_current             = st.cfg.indicator[charger_led_pkg::CURRENT_LSB +: 2]; // RL14
    assign indicator_out                 = st.indicator_out;
    assign battery_isolation_switch_open = st.switch_open;
endmodule

// >>> rtl/charger_led_pkg.sv
// constants and types for the charger indicator and isolation switch configuration bank
package charger_led_pkg;
    // register offsets
    localparam logic [7:0] TEMP_ADJUST_ADDR   = 8'h1a;
    localparam logic [7:0] INPUT_SYS_ADDR     = 8'h1b;
    localparam logic [7:0] INDICATOR_DUTY_ADDR = 8'h1c;
    localparam logic [7:0] FAULT_SWITCH_ADDR  = 8'h1d;
    localparam logic [7:0] INDICATOR_CFG_ADDR = 8'h1e;
    localparam logic [7:0] CHARGER_KEY_ADDR   = 8'h1f;
    // field positions
    localparam int TERM_V_LSB      = 2;
    localparam int CHG_PCT_LSB     = 4;
    localparam int DEBOUNCE_LSB    = 0;
    localparam int THRESHOLD_BIT   = 2;
    localparam int DUTY_LSB        = 0;
    localparam int RAMP_BIT        = 6;
    localparam int DRIVER_EN_BIT   = 7;
    localparam int OVP_KEEP_BIT    = 0;
    localparam int WDOG_KEEP_BIT   = 1;
    localparam int THERM_KEEP_BIT  = 2;
    localparam int TSHDN_KEEP_BIT  = 3;
    localparam int TIMER_KEEP_BIT  = 4;
    localparam int FREQ_LSB        = 0;
    localparam int CURRENT_LSB     = 2;
    localparam int PATTERN_BIT     = 4;
    localparam int OVERRIDE_BIT    = 5;
    // reset values and masks
    localparam logic [7:0] CFG_RESET        = 8'h00;
    localparam logic [7:0] TEMP_ADJUST_MASK = 8'hfc;
    localparam logic [1:0] CURRENT_6MA      = 2'h1;
    localparam logic [5:0] DUTY_SLOTS       = 6'h20;
    // timing
    localparam longint CLK_HZ        = 200_000_000;
    localparam int     DEB_SHORT_US  = 100;
    localparam int     DEB_MID_MS    = 1;
    localparam int     DEB_LONG_MS   = 10;
    localparam int     DEB_SHORT_CYC = int'((CLK_HZ * DEB_SHORT_US) / 1_000_000);
    localparam int     DEB_MID_CYC   = int'((CLK_HZ * DEB_MID_MS) / 1_000);
    localparam int     DEB_LONG_CYC  = int'((CLK_HZ * DEB_LONG_MS) / 1_000);
    // indicator frequencies in millihertz, 32 duty slots per period
    localparam longint FREQ0_MHZ = 1_000;
    localparam longint FREQ1_MHZ = 500;
    localparam longint FREQ2_MHZ = 256_000;
    localparam longint FREQ3_MHZ = 8_000;
    localparam int SLOT0_CYC = int'((CLK_HZ * 1_000) / (FREQ0_MHZ * 32));
    localparam int SLOT1_CYC = int'((CLK_HZ * 1_000) / (FREQ1_MHZ * 32));
    localparam int SLOT2_CYC = int'((CLK_HZ * 1_000) / (FREQ2_MHZ * 32));
    localparam int SLOT3_CYC = int'((CLK_HZ * 1_000) / (FREQ3_MHZ * 32));

    typedef struct packed {
        logic [7:0] temp_adjust;
        logic [7:0] input_sys;
        logic [7:0] duty;
        logic [7:0] fault_switch;
        logic [7:0] indicator;
        logic [7:0] key;
    } cfg_t;

    typedef struct packed {
        logic overvoltage;
        logic watchdog;
        logic thermistor;
        logic thermal_shutdown;
        logic timer;
    } faults_t;

    typedef struct packed {
        cfg_t        cfg;
        logic [23:0] slot_cnt;
        logic [4:0]  slot;
        logic [5:0]  ramp_duty;
        logic        flash_phase;
        logic [23:0] deb_cnt;
        logic        input_sys_ok;
        logic        indicator_out;
        logic        switch_open;
        logic [7:0]  rdata;
        logic        rvalid;
    } state_t;
endpackage

// >>> tb/charger_led_config_regs_sva.sv
// assertion checker for the charger indicator configuration bank
module charger_led_config_regs_sva (
    input wire logic                     mclk,                          // clock
    input wire logic                     resetn,                        // power-on reset
    input wire logic                     core_digital_reset_n,          // core reset
    input wire logic                     reg_wr,                        // write strobe
    input wire logic                     reg_rd,                        // read strobe
    input wire logic                     reg_rvalid,                    // read valid
    input wire charger_led_pkg::faults_t fault_in,                      // faults
    input wire logic                     input_sys_cmp_raw,             // raw level
    input wire logic                     input_sys_ok,                  // debounced
    input wire logic                     input_sys_threshold,           // threshold
    input wire logic [1:0]               term_voltage_subtract,         // voltage code
    input wire logic [1:0]               temp_charge_current_pct,       // current code
    input wire logic [1:0]               indicator_current,             // indicator_current
    input wire logic                     battery_isolation_switch_open  // switch open
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    // fields must sit at zero once the core reset has been held a while
    chk_core_clear: assert property (
        !core_digital_reset_n [*3] |-> {term_voltage_subtract, temp_charge_current_pct,
        indicator_current, input_sys_threshold} == 7'h00)
        else $error("core reset left a field set");
    // field outputs only move on a write or a core reset
    chk_fields_stable: assert property (
        !reg_wr && core_digital_reset_n |=> $stable({term_voltage_subtract,
        temp_charge_current_pct, indicator_current, input_sys_threshold}))
        else $error("field moved without a write");
    chk_current_legal: assert property (
        indicator_current[1] == 1'b0)
        else $error("reserved indicator_current code");
    // shortest debounce is four cycles, so the samples one and four cycles back must agree
    chk_debounce_agree: assert property (
        $changed(input_sys_ok) |-> $past(input_sys_cmp_raw) == input_sys_ok
        && $past(input_sys_cmp_raw, 4) == input_sys_ok)
        else $error("comparator output changed too early");
    chk_switch_idle: assert property (
        fault_in == 5'h00 |=> !battery_isolation_switch_open)
        else $error("switch open without a fault");
    chk_switch_cause: assert property (
        $rose(battery_isolation_switch_open) |-> $past(fault_in) != 5'h00)
        else $error("switch opened with no fault");
    chk_read_answer: assert property (
        reg_rd |=> reg_rvalid)
        else $error("read not answered");
    chk_rvalid_cause: assert property (
        reg_rvalid |-> $past(reg_rd))
        else $error("read valid without a read");
endmodule

bind charger_led_config_regs charger_led_config_regs_sva u_charger_led_config_regs_sva (
    .mclk, .resetn, .core_digital_reset_n, .reg_wr, .reg_rd, .reg_rvalid, .fault_in,
    .input_sys_cmp_raw, .input_sys_ok, .input_sys_threshold, .term_voltage_subtract,
    .temp_charge_current_pct, .indicator_current, .battery_isolation_switch_open);

// >>> tb/test_charger_led_config_regs.sv
// self-checking bench for the charger indicator configuration bank
module test_charger_led_config_regs;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int SL [4] = '{8, 16, 2, 4};
    localparam int DB [4] = '{4, 4, 8, 16};
    logic mclk, resetn, core_digital_reset_n, reg_wr, reg_rd, reg_rvalid;
    logic charging, charger_fault, charge_done, input_sys_cmp_raw, input_sys_ok;
    logic input_sys_threshold, indicator_out, battery_isolation_switch_open;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [1:0] term_voltage_subtract, temp_charge_current_pct, indicator_current;
    logic [15:0] n;
    logic [3:0] pt [5] = '{4'b0100, 4'b0010, 4'b0101, 4'b1100, 4'b1010};
    int pexp [5] = '{128, 64, 0, 64, 128};
    charger_led_pkg::faults_t fault_in;
    int num_errors = 0;
    int checked = 0;

    charger_led_config_regs #(.SLOT0_CYC(SL[0]), .SLOT1_CYC(SL[1]), .SLOT2_CYC(SL[2]),
        .SLOT3_CYC(SL[3]), .DEB_SHORT_CYC(4), .DEB_MID_CYC(8), .DEB_LONG_CYC(16))
    u_charger_led_config_regs (.mclk, .resetn, .core_digital_reset_n, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid, .fault_in, .charging,
        .charger_fault, .charge_done, .input_sys_cmp_raw, .input_sys_ok,
        .input_sys_threshold, .term_voltage_subtract, .temp_charge_current_pct,
        .indicator_current, .indicator_out, .battery_isolation_switch_open);

    // 200 MHz clock
    always #2.5 mclk = ~mclk;

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // strobes last one cycle; a held strobe would repeat the access
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge mclk);
        reg_wr = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge mclk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge mclk);
        reg_rd = 1'b0;
        chk("rvalid", {15'h0, reg_rvalid}, 16'h1);
        chk("rdata", {8'h0, reg_rdata}, {8'h0, exp});
    endtask

    // switch output is registered behind the cfg byte, so wait one cycle more
    task automatic sw(input logic [7:0] k, input logic e);
        wr(8'h1d, k);
        @(negedge mclk);
        chk("switch open", {15'h0, battery_isolation_switch_open}, {15'h0, e});
    endtask

    // any window of whole periods gives the same on-count whatever its phase
    task automatic on_count(input int cyc);
        n = 16'h0;
        repeat (cyc) begin
            @(negedge mclk);
            if (indicator_out === 1'b1) n++;
        end
    endtask

    task automatic deb(input logic lvl, input int exp);
        int k;
        k = 0;
        @(negedge mclk);
        input_sys_cmp_raw = lvl;
        while (input_sys_ok !== lvl && k < 100) begin
            @(negedge mclk);
            k++;
        end
        if (k == 100) begin
            num_errors++;
            print_verdict();
        end
        chk("debounce", 16'(k), 16'(exp));
    endtask

    initial begin
        {mclk, resetn, core_digital_reset_n, reg_wr, reg_rd} = 5'h00;
        {charging, charger_fault, charge_done, input_sys_cmp_raw} = 4'h0;
        {reg_addr, reg_wdata} = 16'h0000;
        fault_in = 5'h00;
        repeat (8) @(negedge mclk);
        resetn = 1'b1;
        core_digital_reset_n = 1'b1;
        for (int a = 8'h1a; a <= 8'h20; a++) rd(8'(a), 8'h00);
        $display("test defaults done");
        for (int c = 0; c < 4; c++) begin
            wr(8'h1a, 8'((c << 4) | (c << 2) | 3));
            rd(8'h1a, 8'((c << 4) | (c << 2)));
            chk("subtract", 16'(term_voltage_subtract), 16'(c));
            chk("charge pct", 16'(temp_charge_current_pct), 16'(c));
        end
        wr(8'h1e, 8'hff);
        rd(8'h1e, 8'hf3);
        wr(8'h1e, 8'h04);
        chk("indicator_current", 16'(indicator_current), 16'h1);
        wr(8'h1e, 8'h0b);
        rd(8'h1e, 8'h07);
        wr(8'h1c, 8'h5a);
        rd(8'h1c, 8'h5a);
        wr(8'h1f, 8'ha5);
        rd(8'h1f, 8'ha5);
        $display("test registers done");
        // fault_in is msb first, so keep bit b pairs with fault bit 4-b
        for (int b = 0; b < 5; b++) begin
            fault_in = 5'(1 << (4 - b));
            sw(8'h00, 1'b1);
            sw(8'(1 << b), 1'b0);
            sw(8'h1f ^ 8'(1 << b), 1'b1);
        end
        fault_in = 5'h00;
        $display("test switch done");
        wr(8'h1d, 8'h1f);
        @(negedge mclk);
        core_digital_reset_n = 1'b0;
        repeat (4) @(negedge mclk);
        core_digital_reset_n = 1'b1;
        rd(8'h1d, 8'h10);
        rd(8'h1e, 8'h00);
        $display("test core reset done");
        wr(8'h1b, 8'h01);
        @(negedge mclk);
        input_sys_cmp_raw = 1'b1;
        repeat (3) @(negedge mclk);
        input_sys_cmp_raw = 1'b0;
        chk("glitch", {15'h0, input_sys_ok}, 16'h0);
        for (int c = 0; c < 4; c++) begin
            wr(8'h1b, 8'(c | 4));
            chk("threshold", {15'h0, input_sys_threshold}, 16'h1);
            deb(1'b1, DB[c]);
            deb(1'b0, DB[c]);
        end
        wr(8'h1b, 8'h00);
        chk("threshold", {15'h0, input_sys_threshold}, 16'h0);
        $display("test debounce done");
        for (int f = 0; f < 4; f++) begin
            wr(8'h1e, 8'(8'h24 | f));
            wr(8'h1c, 8'h88);
            on_count(SL[f] * 32);
            on_count(SL[f] * 32);
            chk("on time", n, 16'(SL[f] * 8));
        end
        wr(8'h1e, 8'h26);
        wr(8'h1c, 8'h80);
        // let the old duty drain out of the registered output first
        on_count(8);
        on_count(128);
        chk("duty zero", n, 16'h0);
        wr(8'h1c, 8'h3f);
        on_count(128);
        chk("driver off", n, 16'h0);
        // shown duty still sits at 63 here; park it at zero before ramping
        wr(8'h1c, 8'h80);
        wr(8'h1c, 8'hc0);
        on_count(128);
        wr(8'h1c, 8'hc8);
        on_count(64);
        chk("ramp start", 16'(n < 16'h8), 16'h1);
        on_count(640);
        on_count(64);
        chk("ramp end", n, 16'h10);
        $display("test indicator done");
        wr(8'h1c, 8'ha0);
        for (int p = 0; p < 5; p++) begin
            {charging, charger_fault, charge_done} = pt[p][2:0];
            wr(8'h1e, {3'h0, pt[p][3], 4'h6});
            on_count(128);
            on_count(128);
            chk("pattern", n, 16'(pexp[p]));
        end
        $display("test pattern done");
        @(negedge mclk);
        resetn = 1'b0;
        repeat (8) @(negedge mclk);
        resetn = 1'b1;
        rd(8'h1d, 8'h00);
        $display("test power-on reset done");
        print_verdict();
    end
endmodule
